// File: verilog/sac_pkg.sv
/*
  sac_pkg: constants, enums and carriers for the serial audio channel pair.
  assumes a single 125 MHz clock domain and no software-visible register bus.
*/
package sac_pkg;
  localparam int unsigned SAC_DATA_W = 32;
  localparam int unsigned SAC_LEN_W = 5;
  localparam int unsigned SAC_FIFO_DEPTH = 8;
  localparam int unsigned SAC_CNT_W = 5;
  localparam logic [SAC_LEN_W-1:0] SAC_LEN_RESET = 5'h0f;
  localparam logic [7:0] SAC_SCK_DIV_RESET = 8'h03;
  // fifo_state_reg field positions
  localparam int unsigned SAC_ST_EMPTY_BIT = 0;
  localparam int unsigned SAC_ST_FULL_BIT = 1;
  localparam int unsigned SAC_ST_UNDERRUN_BIT = 2;
  localparam int unsigned SAC_ST_OVERRUN_BIT = 3;
  localparam int unsigned SAC_ST_W = 4;

  typedef enum logic [1:0]
  {
    SAC_MODE_CLASSIC = 2'h0,
    SAC_MODE_DSP_WS50 = 2'h1,
    SAC_MODE_DSP_WS1 = 2'h2,
    SAC_MODE_DSP_WS1_DATA = 2'h3
  } sac_mode_e;

  typedef enum logic [1:0]
  {
    SAC_IDLE = 2'b00,
    SAC_LEFT = 2'b01,
    SAC_RIGHT = 2'b11
  } sac_state_e;

  // config_one_reg contents, driven as plain inputs
  typedef struct packed
  {
    logic enable;
    logic tx_en;
    logic rx_en;
    sac_mode_e mode;
    logic [SAC_LEN_W-1:0] sample_bit_count;
    logic [7:0] sck_div;
  } sac_cfg_s;

  typedef struct packed
  {
    logic left;
    logic [SAC_DATA_W-1:0] data;
  } sac_word_s;
endpackage : sac_pkg

// File: verilog/sac_fifo.sv
/*
  sac_fifo: the single shared word fifo of one serial interface instance.
  assumes one clock; writer and reader may act in the same cycle.
*/
`timescale 1ns/1ns
module sac_fifo
  import sac_pkg::*;
#(
  parameter int unsigned DEPTH = SAC_FIFO_DEPTH,
  parameter int unsigned AW = 3
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic wr_valid,
  output logic wr_ready,
  input sac_word_s wr_word,
  output logic rd_valid,
  input wire logic rd_ready,
  output sac_word_s rd_word
);
  sac_word_s mem_q [DEPTH];
  logic [AW:0] count_q;
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic do_wr;
  logic do_rd;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_inc

  assign wr_ready = (count_q != (AW+1)'(DEPTH));
  assign rd_valid = (count_q != '0);
  assign rd_word = mem_q[rp_q];
  assign do_wr = wr_valid && wr_ready;
  assign do_rd = rd_valid && rd_ready;

  always_ff @(posedge clock)
  begin
    if (do_wr)
      mem_q[wp_q] <= wr_word;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      count_q <= '0;
    end
    else if (flush)
    begin
      wp_q <= '0;
      rp_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (do_wr)
        wp_q <= ptr_inc(wp_q);
      if (do_rd)
        rp_q <= ptr_inc(rp_q);
      if (do_wr && !do_rd)
        count_q <= count_q + 1'b1;
      else if (do_rd && !do_wr)
        count_q <= count_q - 1'b1;
    end
  end
endmodule : sac_fifo

// File: verilog/sac_channel_pair.sv
/*
  sac_channel_pair: serial audio master for one stereo channel pair.
  assumes the codec samples sd_out on the rising bit clock edge and drives sd_in on the
  falling edge; configuration inputs are held stable while enabled.
*/
`timescale 1ns/1ns
// Functional notes
// - a transmit fifo running dry mid-transfer sets the sticky underrun flag and raises the interrupt.
// - all audio words of this instance, both ways, go through its one shared fifo.
// - the instance carries exactly one channel pair, a left and a right channel.
// - sample_bit_count plus one is the number of bits per channel sent or received.
// - several modes pick the frame timing, and the width applies the same in every mode.
module sac_channel_pair
  import sac_pkg::*;
#(
  parameter int unsigned DEPTH = SAC_FIFO_DEPTH
)
(
  input wire logic clock,
  input wire logic reset_n,
  input sac_cfg_s config_one_reg,
  input wire logic host_wr_valid,
  input sac_word_s host_wr_word,
  output logic host_wr_ready,
  input wire logic host_rd_ready,
  output logic host_rd_valid,
  output sac_word_s host_rd_word,
  input wire logic underrun_clear,
  input wire logic overrun_clear,
  input wire logic sd_in,
  output logic sck,
  output logic ws,
  output logic sd_out,
  output logic [SAC_ST_W-1:0] fifo_state_reg,
  output logic irq
);
  sac_state_e state_q;
  logic [7:0] div_q;
  logic sck_q;
  logic ws_q;
  logic sd_out_q;
  logic [SAC_CNT_W-1:0] bit_q;
  logic [SAC_DATA_W-1:0] tx_sh_q;
  logic [SAC_DATA_W-1:0] rx_sh_q;
  logic underrun_q;
  logic overrun_q;
  logic rx_push_q;
  sac_word_s rx_word_q;
  logic [SAC_ST_W-1:0] stat_q;
  logic irq_q;
  logic rd_valid_q;
  sac_word_s rd_word_q;
  logic wr_ready_q;
  logic rise;
  logic fall;
  logic last_bit;
  logic tx_mode;
  logic fifo_wr_valid;
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic tx_pop;
  logic starve;
  sac_word_s fifo_wr_word;
  sac_word_s fifo_rd_word;

  // word select level for the given channel and bit index per mode
  function automatic logic ws_level(input sac_mode_e m, input logic right, input logic [SAC_CNT_W-1:0] b);
    case (m)
      SAC_MODE_CLASSIC: ws_level = right;
      SAC_MODE_DSP_WS50: ws_level = !right;
      SAC_MODE_DSP_WS1: ws_level = !right && (b == '0);
      SAC_MODE_DSP_WS1_DATA: ws_level = (b == '0);
      default: ws_level = right;
    endcase
  endfunction : ws_level

  assign rise = (div_q == config_one_reg.sck_div) && !sck_q;
  assign fall = (div_q == config_one_reg.sck_div) && sck_q;
  // bit count from width minus one
  assign last_bit = (bit_q == config_one_reg.sample_bit_count);
  assign tx_mode = config_one_reg.enable && config_one_reg.tx_en;
  // one fifo: transmit when tx enabled, else receive
  assign fifo_wr_valid = tx_mode ? host_wr_valid : rx_push_q;
  assign fifo_wr_word = tx_mode ? host_wr_word : rx_word_q;
  assign tx_pop = tx_mode && fall && (bit_q == '0) && (state_q != SAC_IDLE);
  assign starve = tx_pop && !fifo_rd_valid;
  assign fifo_rd_ready = tx_mode ? tx_pop : (host_rd_ready && rd_valid_q == 1'b0);

  sac_fifo #(
    .DEPTH(DEPTH),
    .AW($clog2(DEPTH))
  ) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .flush(!config_one_reg.enable),
    .wr_valid(fifo_wr_valid),
    .wr_ready(fifo_wr_ready),
    .wr_word(fifo_wr_word),
    .rd_valid(fifo_rd_valid),
    .rd_ready(fifo_rd_ready),
    .rd_word(fifo_rd_word)
  );

  // bit clock divider
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_q <= '0;
      sck_q <= 1'b0;
    end
    else if (!config_one_reg.enable)
    begin
      div_q <= '0;
      sck_q <= 1'b0;
    end
    else if (div_q == config_one_reg.sck_div)
    begin
      div_q <= '0;
      sck_q <= !sck_q;
    end
    else
      div_q <= div_q + 1'b1;
  end

  // frame walks left then right only
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= SAC_IDLE;
      bit_q <= '0;
    end
    else if (!config_one_reg.enable)
    begin
      state_q <= SAC_IDLE;
      bit_q <= '0;
    end
    else if (fall)
    begin
      case (state_q)
        SAC_IDLE: state_q <= SAC_LEFT;
        SAC_LEFT:
          if (last_bit)
          begin
            state_q <= SAC_RIGHT;
            bit_q <= '0;
          end
          else
            bit_q <= bit_q + 1'b1;
        SAC_RIGHT:
          if (last_bit)
          begin
            state_q <= SAC_LEFT;
            bit_q <= '0;
          end
          else
            bit_q <= bit_q + 1'b1;
        default: state_q <= SAC_IDLE;
      endcase
    end
  end

  // transmit shifter, msb first; zero when starved
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_sh_q <= '0;
      sd_out_q <= 1'b0;
      ws_q <= 1'b0;
    end
    else if (fall && state_q != SAC_IDLE)
    begin
      ws_q <= ws_level(config_one_reg.mode, state_q == SAC_RIGHT, bit_q);
      if (bit_q == '0)
      begin
        tx_sh_q <= (tx_pop && fifo_rd_valid) ? (fifo_rd_word.data << 1) : '0;
        sd_out_q <= (tx_pop && fifo_rd_valid) ? fifo_rd_word.data[config_one_reg.sample_bit_count] : 1'b0;
      end
      else
      begin
        tx_sh_q <= tx_sh_q << 1;
        sd_out_q <= tx_sh_q[config_one_reg.sample_bit_count];
      end
    end
    else if (!config_one_reg.enable)
    begin
      sd_out_q <= 1'b0;
      ws_q <= 1'b0;
    end
  end

  // receive shifter keeps all bits through the msb
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_sh_q <= '0;
      rx_push_q <= 1'b0;
      rx_word_q <= '0;
    end
    else
    begin
      rx_push_q <= 1'b0;
      if (rise && state_q != SAC_IDLE && config_one_reg.rx_en && !tx_mode)
      begin
        rx_sh_q <= {rx_sh_q[SAC_DATA_W-2:0], sd_in};
        if (last_bit)
        begin
          rx_word_q.left <= (state_q == SAC_LEFT);
          rx_word_q.data <= {rx_sh_q[SAC_DATA_W-2:0], sd_in};
          rx_push_q <= 1'b1;
          rx_sh_q <= '0;
        end
      end
      // drop a part word cut by disable
      else if (!config_one_reg.enable)
        rx_sh_q <= '0;
    end
  end

  // sticky flags, set beats clear
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      underrun_q <= 1'b0;
      overrun_q <= 1'b0;
    end
    else
    begin
      if (starve)
        underrun_q <= 1'b1;
      else if (underrun_clear)
        underrun_q <= 1'b0;
      if (rx_push_q && !fifo_wr_ready)
        overrun_q <= 1'b1;
      else if (overrun_clear)
        overrun_q <= 1'b0;
    end
  end

  // registered outputs
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stat_q <= '0;
      irq_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_word_q <= '0;
      wr_ready_q <= 1'b0;
    end
    else
    begin
      stat_q[SAC_ST_EMPTY_BIT] <= !fifo_rd_valid;
      stat_q[SAC_ST_FULL_BIT] <= !fifo_wr_ready;
      stat_q[SAC_ST_UNDERRUN_BIT] <= underrun_q || starve;
      stat_q[SAC_ST_OVERRUN_BIT] <= overrun_q;
      irq_q <= underrun_q || starve || overrun_q;
      wr_ready_q <= tx_mode && fifo_wr_ready;
      if (rd_valid_q && host_rd_ready)
        rd_valid_q <= 1'b0;
      else if (!tx_mode && fifo_rd_valid && fifo_rd_ready)
      begin
        rd_valid_q <= 1'b1;
        rd_word_q <= fifo_rd_word;
      end
    end
  end

  assign sck = sck_q;
  assign ws = ws_q;
  assign sd_out = sd_out_q;
  assign fifo_state_reg = stat_q;
  assign irq = irq_q;
  assign host_wr_ready = wr_ready_q;
  assign host_rd_valid = rd_valid_q;
  assign host_rd_word = rd_word_q;
endmodule : sac_channel_pair

// File: bench/sac_checker.sv
/*
  sac_checker: port assertions for sac_channel_pair.
  assumes a bind onto the top module and one clock domain.
*/
`timescale 1ns/1ns
module sac_checker
  import sac_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input sac_cfg_s config_one_reg,
  input wire logic host_rd_ready,
  input wire logic host_rd_valid,
  input sac_word_s host_rd_word,
  input wire logic underrun_clear,
  input wire logic overrun_clear,
  input wire logic sck,
  input wire logic ws,
  input wire logic sd_out,
  input wire logic [SAC_ST_W-1:0] fifo_state_reg,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence run_s;
    config_one_reg.enable && $past(config_one_reg.enable, 2);
  endsequence
  sequence sck_fall_s;
    $fell(sck);
  endsequence
  ws_edge_a: assert property (run_s ##0 $changed(ws) |-> sck_fall_s)
    else $error("ws moved off a bit clock fall");
  sd_edge_a: assert property (run_s ##0 config_one_reg.tx_en && $changed(sd_out) |-> sck_fall_s)
    else $error("sd_out moved off a bit clock fall");
  under_hold_a: assert property (fifo_state_reg[2] && !underrun_clear && !$past(underrun_clear) |=> fifo_state_reg[2])
    else $error("underrun flag lost");
  over_hold_a: assert property (fifo_state_reg[3] && !overrun_clear && !$past(overrun_clear) |=> fifo_state_reg[3])
    else $error("overrun flag lost");
  under_irq_a: assert property (fifo_state_reg[2] [*2] |-> irq)
    else $error("underrun without irq");
  irq_cause_a: assert property ($rose(irq) |-> (|fifo_state_reg[3:2]) || $past(|fifo_state_reg[3:2]))
    else $error("irq without flag");
  flags_excl_a: assert property (!(fifo_state_reg[0] && fifo_state_reg[1]))
    else $error("fifo empty and full");
  rx_hold_a: assert property (host_rd_valid && !host_rd_ready |=> host_rd_valid && $stable(host_rd_word))
    else $error("rx word not held");
endmodule : sac_checker

bind sac_channel_pair sac_checker chk (.clock, .reset_n, .config_one_reg, .host_rd_ready, .host_rd_valid,
  .host_rd_word, .underrun_clear, .overrun_clear, .sck, .ws, .sd_out, .fifo_state_reg, .irq);

// File: bench/sac_codec.sv
/*
  sac_codec: behavioural audio converter on the serial link.
  assumes the block masters sck and ws; samples on rising sck.
*/
`timescale 1ns/1ns
module sac_codec
(
  input wire logic en,
  input wire logic sck,
  input wire logic ws,
  input wire logic sd_out,
  output logic sd_in,
  output logic [31:0] cap
);
  logic [31:0] sh = 32'h0;
  // full scale in frame, inverted level once released
  assign sd_in = en;
  initial cap = 32'h0;
  always @(posedge sck)
    if (ws)
      sh <= {sh[30:0], sd_out};
  always @(negedge ws)
    cap <= sh;
endmodule : sac_codec

// File: bench/tb_top.sv
/*
  tb_top: self-checking bench for sac_channel_pair.
  assumes sac_codec on the link and the bound sac_checker.
*/
`timescale 1ns/1ns
module tb_top;
  import sac_pkg::*;
  logic clock, reset_n, wr_v, wr_r, rd_r, rd_v, u_clr, o_clr, sd_in, sck, ws, sd_out, irq;
  sac_cfg_s cfg;
  sac_word_s wr_w, rd_w;
  logic [3:0] st;
  logic [31:0] cap;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  sac_channel_pair uut (.clock, .reset_n, .config_one_reg(cfg), .host_wr_valid(wr_v), .host_wr_word(wr_w),
    .host_wr_ready(wr_r), .host_rd_ready(rd_r), .host_rd_valid(rd_v), .host_rd_word(rd_w),
    .underrun_clear(u_clr), .overrun_clear(o_clr), .sd_in, .sck, .ws, .sd_out, .fifo_state_reg(st), .irq);
  sac_codec codec (.en(cfg.enable), .sck, .ws, .sd_out, .sd_in, .cap);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic results;
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic off;
    cfg.enable = 1'b0;
    repeat (4) @(negedge clock);
  endtask : off
  task automatic wt(input logic v);
    for (int i = 0; i < 3000 && ws !== v; i++) @(negedge clock);
  endtask : wt
  // sck rises between two ws rises
  task automatic t_frame(input logic [1:0] m, input logic [4:0] w);
    int n;
    int k;
    logic ps;
    logic pw;
    n = 0;
    k = 0;
    ps = 1'b0;
    pw = 1'b1;
    cfg = '{1'b1, 1'b0, 1'b1, sac_mode_e'(m), w, 8'h00};
    for (int i = 0; i < 1000 && k < 2; i++)
    begin
      @(negedge clock);
      if (sck && !ps && k == 1)
        n++;
      if (ws && !pw)
        k++;
      ps = sck;
      pw = ws;
    end
    chk(32'(n), (m == 2'h3 ? 32'h1 : 32'h2) * (32'(w) + 32'h1));
    off();
  endtask : t_frame
  task automatic t_tx;
    logic [31:0] wd [4];
    wd = '{32'h8000_00a5, 32'h0123_4567, 32'h5a00_0001, 32'hfedc_ba98};
    cfg = '{1'b1, 1'b1, 1'b0, SAC_MODE_DSP_WS50, 5'h1f, 8'h0f};
    for (int i = 0; i < 20 && wr_r !== 1'b1; i++) @(negedge clock);
    for (int i = 0; i < 4; i++)
    begin
      wr_w = '{i[0] == 1'b0, wd[i]};
      wr_v = 1'b1;
      @(negedge clock);
    end
    wr_v = 1'b0;
    wt(1'b1);
    wt(1'b0);
    chk(cap, wd[0]);
    chk({31'h0, st[2]}, 32'h0);
    wt(1'b1);
    wt(1'b0);
    chk(cap, wd[2]);
    for (int i = 0; i < 3000 && st[2] !== 1'b1; i++) @(negedge clock);
    @(negedge clock);
    chk({30'h0, st[2], irq}, 32'h3);
    off();
    u_clr = 1'b1;
    @(negedge clock);
    u_clr = 1'b0;
    repeat (2) @(negedge clock);
    chk({30'h0, st[2], irq}, 32'h0);
  endtask : t_tx
  task automatic t_rx(input logic [4:0] w);
    logic [31:0] mk;
    mk = 32'hffff_ffff >> (5'h1f - w);
    rd_r = 1'b0;
    cfg = '{1'b1, 1'b0, 1'b1, SAC_MODE_CLASSIC, w, 8'h01};
    repeat (1600) @(negedge clock);
    chk({31'h0, st[3]}, 32'h1);
    rd_r = 1'b1;
    @(negedge clock);
    chk({31'h0, rd_v}, 32'h1);
    chk(rd_w.data, mk);
    chk({31'h0, rd_w.left}, 32'h1);
    repeat (2) @(negedge clock);
    chk({31'h0, rd_v}, 32'h1);
    chk(rd_w.data, mk);
    chk({31'h0, rd_w.left}, 32'h0);
    off();
    o_clr = 1'b1;
    @(negedge clock);
    o_clr = 1'b0;
    repeat (2) @(negedge clock);
    chk({30'h0, st[3], irq}, 32'h0);
  endtask : t_rx
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      results();
    end
  end
  initial
  begin
    reset_n = 1'b0;
    cfg = '0;
    wr_v = 1'b0;
    wr_w = '0;
    rd_r = 1'b1;
    u_clr = 1'b0;
    o_clr = 1'b0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      t_frame(m[1:0], 5'h18);
      t_frame(m[1:0], 5'h1f);
    end
    t_tx();
    t_rx(5'h1f);
    t_rx(5'h18);
    results();
  end
endmodule : tb_top
